// ==== isp_pkg.sv ====
package isp_pkg;
  // Outgoing stream buffer shape.
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W = 5;

  // Register indices that carry content; everything below is reserved.
  localparam logic [7:0] REG_CNT_HI = 8'hfd;
  localparam logic [7:0] REG_CNT_LO = 8'hfe;
  localparam logic [7:0] REG_STREAM = 8'hff;

  // Reset and answer values.
  localparam logic [7:0] PTR_RESET = 8'hff;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [7:0] RSVD_BYTE = 8'h00;

  // Bit counter end and write-segment byte tally.
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] WCNT_NONE = 2'h0;
  localparam logic [1:0] WCNT_ONE = 2'h1;
  localparam logic [1:0] WCNT_MANY = 2'h2;

  // Two-wire slave protocol states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WDATA,
    ST_RDATA,
    ST_RACK,
    ST_RNEXT
  } isp_state_t;
endpackage : isp_pkg

// ==== isp_fifo_if.sv ====
`timescale 1ns/100ps
interface isp_fifo_if;
  import isp_pkg::*;
  logic wr_valid;
  logic wr_ready;
  logic [FIFO_WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [FIFO_WIDTH-1:0] rd_data;
  logic [LVL_W-1:0] level;

  // The port side fills and drains; the buffer side stores.
  modport port_side (output wr_valid, wr_data, rd_ready,
                     input wr_ready, rd_valid, rd_data, level);
  modport buf_side (input wr_valid, wr_data, rd_ready,
                    output wr_ready, rd_valid, rd_data, level);
endinterface : isp_fifo_if

// ==== isp_fifo.sv ====
`timescale 1ns/100ps
module isp_fifo
  import isp_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Buffer ports.
  isp_fifo_if.buf_side f
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] rd_ptr_nxt;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic [WIDTH-1:0] rd_data_r;
  logic wr_ready_r;
  logic push;
  logic pop;

  // Handshakes and next occupancy.
  assign push = f.wr_valid & wr_ready_r;
  assign pop = f.rd_ready & (count_r != '0);
  assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign rd_ptr_nxt = pop ? rd_ptr_r + {{(AW-1){1'b0}}, 1'b1} : rd_ptr_r;
  assign f.wr_ready = wr_ready_r;
  assign f.rd_valid = (count_r != '0);
  assign f.rd_data = rd_data_r;
  assign f.level = count_r;

  // Storage array; no reset needed since the count guards it.
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= f.wr_data;
    end
  end

  // Pointers, count and registered full flag.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      wr_ready_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
      wr_ready_r <= (count_nxt != (AW+1)'(DEPTH));
    end
  end

  // Head word held in a register, bypassing a write into the head slot.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_r <= '0;
    end else if (push && (wr_ptr_r == rd_ptr_nxt)) begin
      rd_data_r <= f.wr_data;
    end else begin
      rd_data_r <= mem_r[rd_ptr_nxt];
    end
  end
endmodule : isp_fifo

// ==== isp_stream_port.sv ====
`timescale 1ns/100ps
module isp_stream_port
  import isp_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Two-wire bus pins; the enable high pulls the data line low.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Configuration and strap.
  input wire logic [7:0] slave_addr_cfg_in,
  input wire logic if_sel_strap_in,
  output logic i2c_mode_out,
  // Outgoing message stream from the receiver.
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic tx_drop_out,
  // Incoming message bytes to the receiver.
  output logic [7:0] rx_data_out,
  output logic rx_valid_out
);
  isp_fifo_if fif ();

  logic scl_s1_r;
  logic scl_s2_r;
  logic scl_s3_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_s3_r;
  logic strap_s1_r;
  logic strap_s2_r;
  logic mode_r;
  isp_state_t state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic rw_r;
  logic ack_on_r;
  logic sda_oe_r;
  logic sda_lvl_r;
  logic [7:0] ptr_r;
  logic [15:0] snap_r;
  logic [1:0] wcnt_r;
  logic [7:0] held_r;
  logic [7:0] rx_data_r;
  logic rx_valid_r;
  logic tx_drop_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic seg_end;
  logic run_ok;
  logic byte_in;
  logic wbyte_in;
  logic addr_hit;
  logic load_now;
  logic [7:0] byte_val;
  logic [7:0] tx_byte;

  // Outgoing stream buffer; the bus master drains it, so it can fill.
  isp_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) isp_fifo_inst (
    .clk_in(sys_clk_in),
    .rst_in(rst_in),
    .f(fif)
  );

  // Pin synchronisers; the third stage only serves edge detection.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end else begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  // Strap sampling; an open strap pin reads high and selects this port.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
      mode_r <= 1'b0;
    end else begin
      strap_s1_r <= if_sel_strap_in;
      strap_s2_r <= strap_s1_r;
      mode_r <= strap_s2_r;
    end
  end

  // Bus events seen on the synchronised lines.
  assign scl_rise = scl_s2_r & ~scl_s3_r;
  assign scl_fall = ~scl_s2_r & scl_s3_r;
  assign start_det = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  assign stop_det = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
  assign seg_end = start_det | stop_det;
  assign run_ok = mode_r & ~seg_end;
  assign byte_val = {shift_r[6:0], sda_s2_r};
  assign byte_in = run_ok & scl_rise & (bit_cnt_r == BIT_LAST);
  assign wbyte_in = byte_in & (state_r == ST_WDATA);
  assign addr_hit = (shift_r[6:0] == slave_addr_cfg_in[7:1]);

  // A read byte is fetched on the falling clock that opens it.
  assign load_now = run_ok & scl_fall &
                    (((state_r == ST_ACK) & ack_on_r & rw_r) | (state_r == ST_RNEXT));
  assign fif.rd_ready = load_now & (ptr_r == REG_STREAM) & fif.rd_valid;
  assign fif.wr_valid = tx_valid_in;
  assign fif.wr_data = tx_data_in;

  // Register decode for the byte about to be sent.
  always_comb begin
    if (ptr_r == REG_CNT_HI) begin
      tx_byte = snap_r[15:8];
    end else if (ptr_r == REG_CNT_LO) begin
      tx_byte = snap_r[7:0];
    end else if (ptr_r == REG_STREAM) begin
      tx_byte = fif.rd_valid ? fif.rd_data : FILL_BYTE;
    end else begin
      tx_byte = RSVD_BYTE;
    end
  end

  // Protocol engine: address, acknowledge, data in and data out.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= '0;
      shift_r <= '0;
      rw_r <= 1'b0;
      ack_on_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (!mode_r || stop_det) begin
      state_r <= ST_IDLE;
      ack_on_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      state_r <= ST_ADDR;
      bit_cnt_r <= '0;
      ack_on_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          bit_cnt_r <= '0;
        end
        ST_ADDR, ST_WDATA: begin
          if (scl_rise) begin
            shift_r <= byte_val;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == BIT_LAST) begin
              if (state_r == ST_WDATA) begin
                state_r <= ST_ACK;
              end else if (addr_hit) begin
                state_r <= ST_ACK;
                rw_r <= sda_s2_r;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (!ack_on_r) begin
              ack_on_r <= 1'b1;
              sda_oe_r <= 1'b1;
            end else begin
              ack_on_r <= 1'b0;
              bit_cnt_r <= '0;
              if (rw_r) begin
                state_r <= ST_RDATA;
                shift_r <= tx_byte;
                sda_oe_r <= ~tx_byte[7];
              end else begin
                state_r <= ST_WDATA;
                sda_oe_r <= 1'b0;
              end
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_r == BIT_LAST) begin
              state_r <= ST_RACK;
              bit_cnt_r <= '0;
              sda_oe_r <= 1'b0;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              sda_oe_r <= ~shift_r[6];
              bit_cnt_r <= bit_cnt_r + 3'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            state_r <= sda_s2_r ? ST_IDLE : ST_RNEXT;
          end
        end
        ST_RNEXT: begin
          if (scl_fall) begin
            state_r <= ST_RDATA;
            shift_r <= tx_byte;
            sda_oe_r <= ~tx_byte[7];
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Register pointer: loaded by a lone written byte, stepped by reads.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_r <= PTR_RESET;
    end else if (seg_end && (wcnt_r == WCNT_ONE)) begin
      ptr_r <= held_r;
    end else if (load_now && (ptr_r != REG_STREAM)) begin
      ptr_r <= ptr_r + 8'h01;
    end
  end

  // Pending count captured at each read address so both bytes agree.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      snap_r <= '0;
    end else if ((state_r == ST_ADDR) && byte_in && addr_hit && sda_s2_r) begin
      snap_r <= 16'(fif.level);
    end
  end

  // Written bytes: one held back so a lone byte never becomes a message.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wcnt_r <= WCNT_NONE;
      held_r <= '0;
      rx_data_r <= '0;
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= 1'b0;
      if (seg_end) begin
        if (wcnt_r == WCNT_MANY) begin
          rx_data_r <= held_r;
          rx_valid_r <= 1'b1;
        end
        wcnt_r <= WCNT_NONE;
      end else if (wbyte_in) begin
        held_r <= byte_val;
        if (wcnt_r != WCNT_NONE) begin
          rx_data_r <= held_r;
          rx_valid_r <= 1'b1;
          wcnt_r <= WCNT_MANY;
        end else begin
          wcnt_r <= WCNT_ONE;
        end
      end
    end
  end

  // Drop indication for bytes offered while the buffer is full.
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_drop_r <= 1'b0;
      sda_lvl_r <= 1'b0;
    end else begin
      tx_drop_r <= tx_valid_in & ~fif.wr_ready;
      sda_lvl_r <= 1'b0;
    end
  end

  // Outputs, each taken from a flip-flop.
  assign sda_out = sda_lvl_r;
  assign sda_oe_out = sda_oe_r;
  assign i2c_mode_out = mode_r;
  assign tx_ready_out = fif.wr_ready;
  assign tx_drop_out = tx_drop_r;
  assign rx_data_out = rx_data_r;
  assign rx_valid_out = rx_valid_r;

  // Checks on the protocol engine, the pointer, messages, drops and the count snapshot.
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_addr_hit;
    (state_r == ST_ADDR) && byte_in && addr_hit;
  endsequence

  sequence s_addr_miss;
    (state_r == ST_ADDR) && byte_in && !addr_hit;
  endsequence

  AST_ACK_HIT: assert property (
    s_addr_hit |=> (state_r == ST_ACK) ##[1:100] sda_oe_r)
    else $error("Matching address was not acknowledged.");
  AST_NO_ACK_MISS: assert property (
    s_addr_miss |=> (state_r == ST_IDLE) ##0 !sda_oe_r [*4])
    else $error("Bus driven after a foreign address.");
  AST_PTR_STEP: assert property (
    load_now && (ptr_r != REG_STREAM) |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("Pointer did not advance after a read.");
  AST_PTR_HOLD: assert property (
    load_now && (ptr_r == REG_STREAM) |=> ptr_r == REG_STREAM)
    else $error("Pointer left the stream register.");
  AST_FILL: assert property (
    load_now && (ptr_r == REG_STREAM) && !fif.rd_valid |=>
      (shift_r == FILL_BYTE) && !sda_oe_r)
    else $error("Empty stream did not answer with the filler byte.");
  AST_PTR_LOAD: assert property (
    seg_end && (wcnt_r == WCNT_ONE) |=> (ptr_r == $past(held_r)) && !rx_valid_r)
    else $error("Single written byte did not load the pointer.");
  AST_MSG_OUT: assert property (
    seg_end && (wcnt_r == WCNT_MANY) |=> rx_valid_r && (rx_data_r == $past(held_r)))
    else $error("Last written byte was not passed on.");
  AST_DROP: assert property (
    tx_valid_in && !fif.wr_ready && !fif.rd_ready |=> tx_drop_r && $stable(fif.level))
    else $error("Byte offered to a full buffer was not discarded.");
  AST_STRAP: assert property (
    !mode_r |=> !sda_oe_r && (state_r == ST_IDLE))
    else $error("Port active with the strap low.");
  AST_SNAP: assert property (
    state_r != ST_ADDR |=> $stable(snap_r))
    else $error("Pending count changed outside an address phase.");
endmodule : isp_stream_port

// ==== isp_host_model.sv ====
`timescale 1ns/100ps
// Behavioural bus master that answers the port from the host side.
// The clock stands high between frames, and the data line is only ever
// pulled low or released, so the wire takes the pull-up level when idle.
module isp_host_model (
  // Bus lines seen and driven by the master.
  output logic scl_out,
  output logic sda_pull_out,
  input wire logic sda_in
);
  // Idle bus: clock high, data released.
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  // One bit out: data changes late in the 200 ns low phase, 120 ns high phase.
  task automatic send_bit(input logic b);
    scl_out = 1'b0;
    #160;
    sda_pull_out = ~b;
    #40;
    scl_out = 1'b1;
    #120;
  endtask : send_bit

  // One bit in: the line is released and sampled in mid high phase.
  task automatic recv_bit(output logic b);
    scl_out = 1'b0;
    #160;
    sda_pull_out = 1'b0;
    #40;
    scl_out = 1'b1;
    #60;
    b = sda_in;
    #60;
  endtask : recv_bit

  // Start or repeated start; the release waits for the port's acknowledge to end.
  task automatic start_cond();
    #13;
    scl_out = 1'b0;
    #160;
    sda_pull_out = 1'b0;
    #40;
    scl_out = 1'b1;
    #120;
    sda_pull_out = 1'b1;
    #120;
  endtask : start_cond

  // Stop: data rises while the clock is high, then the bus stays idle.
  task automatic stop_cond();
    scl_out = 1'b0;
    #160;
    sda_pull_out = 1'b1;
    #40;
    scl_out = 1'b1;
    #120;
    sda_pull_out = 1'b0;
    #200;
  endtask : stop_cond

  // Byte out, most significant bit first, then the port's acknowledge.
  task automatic put_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i]);
    end
    recv_bit(ack);
  endtask : put_byte

  // Byte in; the last byte of a read is answered with a not-acknowledge.
  task automatic get_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) begin
      recv_bit(d[i]);
    end
    send_bit(last);
  endtask : get_byte
endmodule : isp_host_model

// ==== isp_stream_port_test.sv ====
`timescale 1ns/100ps
module isp_stream_port_test;
  import isp_pkg::*;
  // Address bit 0 is set to show that the direction bit of the setting is ignored.
  localparam logic [6:0] DEV_ADDR = 7'h42;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic scl;
  logic host_pull;
  logic sda_out;
  logic sda_oe_out;
  logic if_sel_strap_in = 1'b1;
  logic i2c_mode_out;
  logic [7:0] tx_data_in = 8'h00;
  logic tx_valid_in = 1'b0;
  logic tx_ready_out;
  logic tx_drop_out;
  logic [7:0] rx_data_out;
  logic rx_valid_out;
  wire logic sda_line;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] rx_q[$];
  logic [7:0] got[$];
  logic [7:0] exp_q[$];
  logic dr;
  logic a;

  // Wired data line with a pull-up.
  assign sda_line = ~(host_pull | sda_oe_out);

  // System clock, 40 ns period.
  always #20 sys_clk_in = ~sys_clk_in;

  isp_stream_port isp_stream_port_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .slave_addr_cfg_in({DEV_ADDR, 1'b1}),
    .if_sel_strap_in(if_sel_strap_in), .i2c_mode_out(i2c_mode_out),
    .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
    .tx_drop_out(tx_drop_out), .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out)
  );

  isp_host_model isp_host_model_inst (.scl_out(scl), .sda_pull_out(host_pull),
    .sda_in(sda_line));

  // Collects every incoming message byte the port hands on.
  always @(posedge sys_clk_in) begin
    if (rx_valid_out === 1'b1) begin
      rx_q.push_back(rx_data_out);
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Offers one stream byte and reports whether the port dropped it.
  task automatic push(input logic [7:0] d, output logic dropped);
    @(posedge sys_clk_in);
    tx_data_in <= d;
    tx_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    tx_valid_in <= 1'b0;
    #1 dropped = tx_drop_out;
    @(posedge sys_clk_in);
    #1 dropped = dropped | tx_drop_out;
  endtask : push

  task automatic addr_phase(input logic rd_dir);
    isp_host_model_inst.put_byte({DEV_ADDR, rd_dir}, a);
    check("address ack", 8'h00, {7'h0, a});
  endtask : addr_phase

  // Read of n bytes, with or without a register index first.
  task automatic rd(input bit use_idx, input logic [7:0] idx, input int n);
    logic [7:0] b;
    got.delete();
    // Start from a fixed phase so no pin edge lands on a clock edge.
    @(posedge sys_clk_in);
    isp_host_model_inst.start_cond();
    if (use_idx) begin
      addr_phase(1'b0);
      isp_host_model_inst.put_byte(idx, a);
      check("index ack", 8'h00, {7'h0, a});
      isp_host_model_inst.start_cond();
    end
    addr_phase(1'b1);
    for (int i = 0; i < n; i++) begin
      isp_host_model_inst.get_byte(b, i == n - 1);
      got.push_back(b);
    end
    isp_host_model_inst.stop_cond();
  endtask : rd

  // Write of the given bytes, each one acknowledged, closed by a stop.
  task automatic wr(input logic [7:0] d[$]);
    @(posedge sys_clk_in);
    isp_host_model_inst.start_cond();
    addr_phase(1'b0);
    foreach (d[i]) begin
      isp_host_model_inst.put_byte(d[i], a);
      check("data ack", 8'h00, {7'h0, a});
    end
    isp_host_model_inst.stop_cond();
  endtask : wr

  task automatic expect_q(input string what, input logic [7:0] exp[$]);
    check({what, " size"}, 8'(exp.size()), 8'(got.size()));
    foreach (exp[i]) begin
      check(what, exp[i], (i < got.size()) ? got[i] : 8'hxx);
    end
  endtask : expect_q

  task automatic wait_mode(input logic exp);
    int k;
    k = 0;
    while (i2c_mode_out !== exp && k < 20) begin
      @(posedge sys_clk_in);
      #1 k++;
    end
    check("port enable", {7'h0, exp}, {7'h0, i2c_mode_out});
  endtask : wait_mode

  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // Watchdog, several times the expected run length.
  initial begin
    #2000000;
    miscompares++;
    $display("watchdog expired");
    results();
  end

  initial begin
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    wait_mode(1'b1);
    check("ready after reset", 8'h01, {7'h0, tx_ready_out});
    rd(0, 8'h00, 2);
    expect_q("empty stream", '{FILL_BYTE, FILL_BYTE});
    $display("test empty done");
    for (int i = 0; i < 3; i++) begin
      push(8'(8'h11 + i), dr);
    end
    rd(1, REG_CNT_HI, 3);
    expect_q("count then stream", '{8'h00, 8'h03, 8'h11});
    rd(0, 8'h00, 3);
    expect_q("stream order", '{8'h12, 8'h13, FILL_BYTE});
    $display("test count done");
    rd(1, 8'h10, 1);
    expect_q("reserved", '{RSVD_BYTE});
    push(8'h5a, dr);
    wr('{REG_CNT_HI});
    rd(0, 8'h00, 2);
    expect_q("pointer load", '{8'h00, 8'h01});
    rd(0, 8'h00, 1);
    expect_q("pointer step", '{8'h5a});
    check("no message", 8'h00, 8'(rx_q.size()));
    $display("test pointer done");
    wr('{8'ha5, 8'h3c, 8'h0f});
    repeat (8) @(posedge sys_clk_in);
    got = rx_q;
    expect_q("message in", '{8'ha5, 8'h3c, 8'h0f});
    rd(0, 8'h00, 1);
    expect_q("not writable", '{FILL_BYTE});
    isp_host_model_inst.start_cond();
    isp_host_model_inst.put_byte({DEV_ADDR ^ 7'h01, 1'b0}, a);
    isp_host_model_inst.stop_cond();
    check("foreign ack", 8'h01, {7'h0, a});
    $display("test write done");
    exp_q.delete();
    for (int i = 0; i < 17; i++) begin
      if (i == 16) check("ready when full", 8'h00, {7'h0, tx_ready_out});
      push(8'(i), dr);
      check("drop", {7'h0, i == 16}, {7'h0, dr});
      if (i < 16) exp_q.push_back(8'(i));
    end
    exp_q.push_back(FILL_BYTE);
    rd(1, REG_CNT_HI, 2);
    expect_q("full count", '{8'h00, 8'h10});
    rd(0, 8'h00, 17);
    expect_q("drain", exp_q);
    $display("test full done");
    @(posedge sys_clk_in);
    if_sel_strap_in <= 1'b0;
    wait_mode(1'b0);
    isp_host_model_inst.start_cond();
    isp_host_model_inst.put_byte({DEV_ADDR, 1'b0}, a);
    isp_host_model_inst.stop_cond();
    check("strap low ack", 8'h01, {7'h0, a});
    @(posedge sys_clk_in);
    if_sel_strap_in <= 1'b1;
    wait_mode(1'b1);
    // The data pin is open drain, so its drive value must stay low.
    check("open drain level", 8'h00, {7'h0, sda_out});
    $display("test strap done");
    results();
  end
endmodule : isp_stream_port_test
